// ### logic/dms_pkg.sv
package dms_pkg;

  // Data memory geometry
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned XADDR_W     = 9;
  localparam int unsigned LOC_W       = 8;
  localparam int unsigned SFR_LOC_W   = 7;
  localparam int unsigned GP_SEL_BIT  = 7;
  localparam int unsigned SECTORS     = 2;
  localparam int unsigned GP_BYTES    = 256;
  localparam int unsigned SFR_PER_SEC = 128;

  // APB word index: byte address is four times the extended address
  localparam int unsigned APB_IDX_LSB = 2;
  localparam int unsigned APB_TOP_LSB = APB_IDX_LSB + XADDR_W;

  // Fixed special-function locations (sector zero)
  localparam logic [7:0] LOC_PORT0  = 8'h00;
  localparam logic [7:0] LOC_PTR0   = 8'h01;
  localparam logic [7:0] LOC_PORT1  = 8'h02;
  localparam logic [7:0] LOC_PTR1L  = 8'h03;
  localparam logic [7:0] LOC_PTR1S  = 8'h04;
  localparam logic [7:0] LOC_PORT2  = 8'h0C;
  localparam logic [7:0] LOC_PTR2L  = 8'h0D;
  localparam logic [7:0] LOC_PTR2S  = 8'h0E;

  // Reset and read-back values
  localparam logic [7:0] PTR_RESET  = 8'h00;
  localparam logic [7:0] RAM_RESET  = 8'h00;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  // Command field carried in pwdata on writes
  localparam int unsigned CMD_LSB   = 8;
  localparam int unsigned CMD_W     = 2;
  localparam int unsigned BIT_LSB   = 10;
  localparam int unsigned BIT_W     = 3;
  localparam int unsigned DOWN_BIT  = 13;

  // Unused locations, one bit per in-sector location 00H..7FH
  localparam logic [127:0] UNUSED_SEC0 =
    128'hFF80_0000_0000_0000_8000_0000_0000_0000;
  localparam logic [127:0] UNUSED_SEC1 =
    128'hFFFF_FFFF_FFFF_FFFE_FFFF_FFFF_FFFF_FFFF;
  localparam logic [127:0] MASK_NONE   =
    128'h0000_0000_0000_0000_0000_0000_0000_0000;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_SET   = 2'h1,
    OP_CLR   = 2'h2,
    OP_STEP  = 2'h3
  } dms_op_type;

  typedef enum logic [1:0] {
    CLS_VOID = 2'h0,
    CLS_RAM  = 2'h1,
    CLS_PTR  = 2'h2,
    CLS_EXT  = 2'h3
  } dms_cls_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } dms_state_type;

endpackage : dms_pkg

// ### logic/dms_byte_modify.sv
`timescale 1ns/1ps

module dms_byte_modify (
  // Operand
  input  wire logic [7:0]         old_byte,
  input  wire dms_pkg::dms_op_type op,
  input  wire logic [7:0]         wbyte,
  input  wire logic [2:0]         bit_sel,
  input  wire logic               step_down,
  // Result
  output logic      [7:0]         new_byte
);

  logic [7:0] one_hot;

  always_comb begin
    one_hot = 8'h01 << bit_sel;
    case (op)
      dms_pkg::OP_WRITE: new_byte = wbyte;
      dms_pkg::OP_SET:   new_byte = old_byte | one_hot;
      dms_pkg::OP_CLR:   new_byte = old_byte & ~one_hot;
      dms_pkg::OP_STEP:  new_byte = step_down ? old_byte - 8'h01
                                              : old_byte + 8'h01;
      default:           new_byte = wbyte;
    endcase
  end

endmodule : dms_byte_modify

// ### logic/dms_data_memory_sector_addressing.sv
`timescale 1ns/1ps

// Functional notes
// - Ports one and two take sector from pointer high, location from low.
// - No bank register; sector comes from pointer highs or extended address.
// - Extended address is 9 bits: sector above, in-sector byte below.
// - Direct addressing reaches every sector, not only sector zero.
// - General-purpose bytes read, write, and single-bit set or clear.
// - Protected special locations read normally, writes ignored.
// - Unused special locations read as 00H.
// - Reserved special locations keep their content when written.
// - Access to a virtual port goes to the address its pointer holds.
// - Port zero with its single pointer reaches sector zero only.
// - Ports one and two with pointer pairs reach any sector.
// - Virtual port accessed as itself reads 00H, write does nothing.
// - In-sector 00H-7FH is special area, 80H-FFH general-purpose.
// - 256 general-purpose bytes, 80H-FFH of sectors zero and one.
// - Extended address 1F0H is location 0F0H of sector one.
module dms_data_memory_sector_addressing #(
  parameter int unsigned  PADDR_W     = 12,
  parameter logic [127:0] RO_SEC0     = dms_pkg::MASK_NONE,
  parameter logic [127:0] RO_SEC1     = dms_pkg::MASK_NONE,
  parameter logic [127:0] RSVD_SEC0   = dms_pkg::MASK_NONE,
  parameter logic [127:0] RSVD_SEC1   = dms_pkg::MASK_NONE
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Peripheral special-function port
  output logic                    sfr_sector,
  output logic      [6:0]         sfr_loc,
  output logic                    sfr_rd,
  output logic                    sfr_wr,
  output logic      [7:0]         sfr_wdata,
  input  wire logic [7:0]         sfr_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  dms_pkg::dms_state_type state_ff;
  dms_pkg::dms_state_type nxt_state;
  dms_pkg::dms_cls_type   cls_ff;
  dms_pkg::dms_cls_type   nxt_cls;
  dms_pkg::dms_op_type    op_ff;
  logic [7:0]             idx_ff;
  logic [7:0]             nxt_idx;
  logic                   wr_ok_ff;
  logic                   nxt_wr_ok;
  logic                   write_ff;
  logic                   err_ff;
  logic [7:0]             wdat_ff;
  logic [2:0]             bit_ff;
  logic                   down_ff;

  logic [7:0]             ptr0_ff;
  logic [7:0]             ptr1l_ff;
  logic [7:0]             ptr1s_ff;
  logic [7:0]             ptr2l_ff;
  logic [7:0]             ptr2s_ff;
  logic [7:0]             ram_ff [dms_pkg::GP_BYTES];

  logic [31:0]            prdata_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic                   sfr_sector_ff;
  logic [6:0]             sfr_loc_ff;
  logic                   sfr_rd_ff;
  logic                   sfr_wr_ff;
  logic [7:0]             sfr_wdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address resolution, evaluated in the first access cycle
  logic                   take;
  logic                   bad_addr;
  logic [8:0]             xaddr;
  logic [7:0]             loc_raw;
  logic [7:0]             eff_sec;
  logic [7:0]             eff_loc;
  logic [6:0]             sfr_i;
  logic                   is_port;
  logic                   is_ptr;
  logic                   unused_hit;
  logic                   prot_hit;

  assign take     = psel && penable && (state_ff == dms_pkg::ST_IDLE);
  assign bad_addr = |paddr[PADDR_W-1:dms_pkg::APB_TOP_LSB];
  assign xaddr    = paddr[dms_pkg::APB_IDX_LSB +: dms_pkg::XADDR_W];
  assign loc_raw  = xaddr[7:0];

  always_comb begin
    eff_sec = {7'h00, xaddr[8]};
    eff_loc = loc_raw;
    if (xaddr[8] == 1'b0) begin
      case (loc_raw)
        dms_pkg::LOC_PORT0: begin
          eff_sec = 8'h00;
          eff_loc = ptr0_ff;
        end
        // pair one selects sector and location
        dms_pkg::LOC_PORT1: begin
          eff_sec = ptr1s_ff;
          eff_loc = ptr1l_ff;
        end
        // pair two selects sector and location
        dms_pkg::LOC_PORT2: begin
          eff_sec = ptr2s_ff;
          eff_loc = ptr2l_ff;
        end
        default: begin
          eff_sec = 8'h00;
          eff_loc = loc_raw;
        end
      endcase
    end
  end

  always_comb begin
    sfr_i      = eff_loc[dms_pkg::SFR_LOC_W-1:0];
    is_port    = (eff_sec == 8'h00) &&
                 ((eff_loc == dms_pkg::LOC_PORT0) ||
                  (eff_loc == dms_pkg::LOC_PORT1) ||
                  (eff_loc == dms_pkg::LOC_PORT2));
    is_ptr     = (eff_sec == 8'h00) &&
                 ((eff_loc == dms_pkg::LOC_PTR0)  ||
                  (eff_loc == dms_pkg::LOC_PTR1L) ||
                  (eff_loc == dms_pkg::LOC_PTR1S) ||
                  (eff_loc == dms_pkg::LOC_PTR2L) ||
                  (eff_loc == dms_pkg::LOC_PTR2S));
    unused_hit = eff_sec[0] ? dms_pkg::UNUSED_SEC1[sfr_i]
                            : dms_pkg::UNUSED_SEC0[sfr_i];
    prot_hit   = eff_sec[0] ? (RO_SEC1[sfr_i] || RSVD_SEC1[sfr_i])
                            : (RO_SEC0[sfr_i] || RSVD_SEC0[sfr_i]);
    nxt_idx    = eff_loc;
    nxt_wr_ok  = 1'b0;
    nxt_cls    = dms_pkg::CLS_VOID;
    if (bad_addr) begin
      nxt_cls = dms_pkg::CLS_VOID;
    end else if (eff_sec >= 8'(dms_pkg::SECTORS)) begin
      nxt_cls = dms_pkg::CLS_VOID;
    end else if (eff_loc[dms_pkg::GP_SEL_BIT]) begin
      nxt_cls   = dms_pkg::CLS_RAM;
      nxt_idx   = {eff_sec[0], eff_loc[6:0]};
      nxt_wr_ok = 1'b1;
    end else if (is_ptr) begin
      nxt_cls   = dms_pkg::CLS_PTR;
      nxt_wr_ok = 1'b1;
    end else if (is_port) begin
      nxt_cls = dms_pkg::CLS_VOID;
    end else if (unused_hit) begin
      nxt_cls = dms_pkg::CLS_VOID;
    end else begin
      nxt_cls   = dms_pkg::CLS_EXT;
      nxt_idx   = {eff_sec[0], sfr_i};
      nxt_wr_ok = !prot_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: capture, execute, answer
  always_comb begin
    case (state_ff)
      dms_pkg::ST_IDLE: nxt_state = take ? dms_pkg::ST_EXEC
                                         : dms_pkg::ST_IDLE;
      dms_pkg::ST_EXEC: nxt_state = dms_pkg::ST_DONE;
      dms_pkg::ST_DONE: nxt_state = dms_pkg::ST_IDLE;
      default:          nxt_state = dms_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= dms_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cls_ff   <= dms_pkg::CLS_VOID;
      op_ff    <= dms_pkg::OP_WRITE;
      idx_ff   <= 8'h00;
      wr_ok_ff <= 1'b0;
      write_ff <= 1'b0;
      err_ff   <= 1'b0;
      wdat_ff  <= 8'h00;
      bit_ff   <= 3'h0;
      down_ff  <= 1'b0;
    end else if (take) begin
      cls_ff   <= nxt_cls;
      op_ff    <= dms_pkg::dms_op_type'(
                    pwdata[dms_pkg::CMD_LSB +: dms_pkg::CMD_W]);
      idx_ff   <= nxt_idx;
      wr_ok_ff <= nxt_wr_ok;
      write_ff <= pwrite;
      err_ff   <= bad_addr;
      wdat_ff  <= pwdata[7:0];
      bit_ff   <= pwdata[dms_pkg::BIT_LSB +: dms_pkg::BIT_W];
      down_ff  <= pwdata[dms_pkg::DOWN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Old value, new value and write strobe
  logic [7:0] old_byte;
  logic [7:0] new_byte;
  logic       wr_go;

  always_comb begin
    case (cls_ff)
      dms_pkg::CLS_RAM: old_byte = ram_ff[idx_ff];
      dms_pkg::CLS_EXT: old_byte = sfr_rdata;
      dms_pkg::CLS_PTR: begin
        case (idx_ff)
          dms_pkg::LOC_PTR0:  old_byte = ptr0_ff;
          dms_pkg::LOC_PTR1L: old_byte = ptr1l_ff;
          dms_pkg::LOC_PTR1S: old_byte = ptr1s_ff;
          dms_pkg::LOC_PTR2L: old_byte = ptr2l_ff;
          dms_pkg::LOC_PTR2S: old_byte = ptr2s_ff;
          default:            old_byte = dms_pkg::READ_ZERO;
        endcase
      end
      default:          old_byte = dms_pkg::READ_ZERO;
    endcase
  end

  // Bit ops and steps are read-modify-write, so they need the old byte
  dms_byte_modify u_modify (
    .old_byte  (old_byte),
    .op        (op_ff),
    .wbyte     (wdat_ff),
    .bit_sel   (bit_ff),
    .step_down (down_ff),
    .new_byte  (new_byte)
  );

  assign wr_go = (state_ff == dms_pkg::ST_EXEC) && write_ff && wr_ok_ff;

  ////////////////////////////////////////////////////////////////////////////
  // General-purpose storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < int'(dms_pkg::GP_BYTES); i++) begin
        ram_ff[i] <= dms_pkg::RAM_RESET;
      end
    end else if (wr_go && (cls_ff == dms_pkg::CLS_RAM)) begin
      ram_ff[idx_ff] <= new_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers; a step on a low byte never touches its sector byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr0_ff  <= dms_pkg::PTR_RESET;
      ptr1l_ff <= dms_pkg::PTR_RESET;
      ptr1s_ff <= dms_pkg::PTR_RESET;
      ptr2l_ff <= dms_pkg::PTR_RESET;
      ptr2s_ff <= dms_pkg::PTR_RESET;
    end else if (wr_go && (cls_ff == dms_pkg::CLS_PTR)) begin
      case (idx_ff)
        dms_pkg::LOC_PTR0:  ptr0_ff  <= new_byte;
        dms_pkg::LOC_PTR1L: ptr1l_ff <= new_byte;
        dms_pkg::LOC_PTR1S: ptr1s_ff <= new_byte;
        dms_pkg::LOC_PTR2L: ptr2l_ff <= new_byte;
        dms_pkg::LOC_PTR2S: ptr2s_ff <= new_byte;
        default:            ptr0_ff  <= ptr0_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral port: read strobe in execute, write strobe in answer cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfr_sector_ff <= 1'b0;
      sfr_loc_ff    <= 7'h00;
      sfr_rd_ff     <= 1'b0;
      sfr_wr_ff     <= 1'b0;
      sfr_wdata_ff  <= 8'h00;
    end else begin
      sfr_rd_ff <= take && (nxt_cls == dms_pkg::CLS_EXT);
      if (take) begin
        sfr_sector_ff <= nxt_idx[7];
        sfr_loc_ff    <= nxt_idx[6:0];
      end
      sfr_wr_ff <= wr_go && (cls_ff == dms_pkg::CLS_EXT);
      if (wr_go && (cls_ff == dms_pkg::CLS_EXT)) begin
        sfr_wdata_ff <= new_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (state_ff == dms_pkg::ST_EXEC) begin
      prdata_ff  <= write_ff ? 32'h0000_0000 : {24'h00_0000, old_byte};
      pready_ff  <= 1'b1;
      pslverr_ff <= err_ff;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign sfr_sector = sfr_sector_ff;
  assign sfr_loc    = sfr_loc_ff;
  assign sfr_rd     = sfr_rd_ff;
  assign sfr_wr     = sfr_wr_ff;
  assign sfr_wdata  = sfr_wdata_ff;

endmodule : dms_data_memory_sector_addressing

// ### tb/dms_sva.sv
`timescale 1ns/1ps

module dms_sva #(
  parameter int unsigned PADDR_W = 12
) (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Peripheral port
  input wire logic               sfr_sector,
  input wire logic [6:0]         sfr_loc,
  input wire logic               sfr_rd,
  input wire logic               sfr_wr,
  input wire logic [7:0]         sfr_wdata,
  input wire logic [7:0]         sfr_rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    psel && $rose(penable);
  endsequence
  sequence s_answer;
    !pready ##1 !pready ##1 pready;
  endsequence

  property p_ready_lat;
    s_take |-> s_answer;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_in_xfer;
    pready |-> psel && penable;
  endproperty
  property p_err_map;
    pready |-> (pslverr == paddr[PADDR_W-1]);
  endproperty
  property p_err_only_ready;
    pslverr |-> pready;
  endproperty
  property p_rd_upper;
    pready && !pwrite |-> prdata[31:8] == 24'h00_0000;
  endproperty
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h0000_0000;
  endproperty
  property p_sfr_rd_ans;
    sfr_rd |-> !paddr[PADDR_W-1] ##1 pready;
  endproperty
  property p_sfr_wr_order;
    sfr_wr |-> pready && pwrite && $past(sfr_rd);
  endproperty
  property p_sfr_wdata;
    sfr_wr && pwdata[9:8] == 2'h0 |-> sfr_wdata == pwdata[7:0];
  endproperty

  a_ready_lat: assert property (p_ready_lat)
    else $error("pready not two cycles after take");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_ready_in_xfer: assert property (p_ready_in_xfer)
    else $error("pready outside a transfer");
  a_err_map: assert property (p_err_map)
    else $error("pslverr does not match address decode");
  a_err_only_ready: assert property (p_err_only_ready)
    else $error("pslverr without pready");
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");
  a_wr_zero: assert property (p_wr_zero)
    else $error("prdata not zero on write");
  a_sfr_rd_ans: assert property (p_sfr_rd_ans)
    else $error("peripheral read not answered next cycle");
  a_sfr_wr_order: assert property (p_sfr_wr_order)
    else $error("peripheral write out of order");
  a_sfr_wdata: assert property (p_sfr_wdata)
    else $error("peripheral write data wrong");
endmodule : dms_sva

bind dms_data_memory_sector_addressing dms_sva #(.PADDR_W(PADDR_W)) u_dms_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sfr_sector(sfr_sector),
  .sfr_loc(sfr_loc), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata)
);

// ### tb/dms_sfr_model.sv
`timescale 1ns/1ps

module dms_sfr_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Peripheral port
  input  wire logic       sfr_sector,
  input  wire logic [6:0] sfr_loc,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata
);
  logic [7:0] mem_ff [0:255];
  logic [7:0] last_ff;
  logic [7:0] idx;

  assign idx = {sfr_sector, sfr_loc};
  // special area storage
  // Outside a read the data line shows the inverse, so a stale value fails
  assign sfr_rdata = sfr_rd ? mem_ff[idx] : ~last_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        mem_ff[i] <= 8'(i) ^ 8'h5A;
      end
    end else if (sfr_wr) begin
      mem_ff[idx] <= sfr_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ff <= 8'h00;
    end else if (sfr_rd) begin
      last_ff <= mem_ff[idx];
    end
  end
endmodule : dms_sfr_model

// ### tb/dms_data_memory_sector_addressing_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end

module dms_data_memory_sector_addressing_tb;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sfr_sector;
  logic [6:0]  sfr_loc;
  logic        sfr_rd;
  logic        sfr_wr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        last_err;
  logic [7:0]  junk;
  int          compares    = 0;
  int          miscompares = 0;

  always #2.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  // Location 05H protected, 06H reserved, to exercise dropped writes
  dms_data_memory_sector_addressing #(
    .PADDR_W  (12),
    .RO_SEC0  (128'h0000_0000_0000_0000_0000_0000_0000_0020),
    .RSVD_SEC0(128'h0000_0000_0000_0000_0000_0000_0000_0040)
  ) u_dms_data_memory_sector_addressing (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sfr_sector(sfr_sector),
    .sfr_loc(sfr_loc), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata)
  );

  dms_sfr_model u_dms_sfr_model (
    .pclk(pclk), .presetn(presetn), .sfr_sector(sfr_sector),
    .sfr_loc(sfr_loc), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address a: {unmapped bit, 9-bit extended address}
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {a, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the rising edge that samples pready high
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (n >= 50) begin
        miscompares++;
        end_of_test();
      end
      @(posedge pclk);
      n++;
    end
    r        = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, junk);
  endtask : wr

  task automatic op(input logic [9:0] a, input dms_pkg::dms_op_type o,
                    input logic [2:0] b, input logic dn);
    apb(1'b1, a, {18'h0_0000, dn, b, o, 8'h00}, junk);
  endtask : op

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e,
                        input string n);
    logic [7:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    `CHK(n, e, r)
  endtask : rd_chk

  task automatic end_of_test();
    $display("Compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(10'h001, 8'h00, "ptr0 reset");
    rd_chk(10'h00E, 8'h00, "ptr2 sector reset");
    wr(10'h080, 8'hA5);
    wr(10'h1F0, 8'h3C);
    rd_chk(10'h080, 8'hA5, "gp s0");
    rd_chk(10'h1F0, 8'h3C, "gp 1F0");
    rd_chk(10'h0F0, 8'h00, "gp s0 F0");
    $display("Test general storage done");
    wr(10'h085, 8'h00);
    op(10'h085, dms_pkg::OP_SET, 3'd3, 1'b0);
    rd_chk(10'h085, 8'h08, "set bit3");
    op(10'h085, dms_pkg::OP_SET, 3'd7, 1'b0);
    op(10'h085, dms_pkg::OP_CLR, 3'd3, 1'b0);
    rd_chk(10'h085, 8'h80, "clr bit3");
    $display("Test bit ops done");
    wr(10'h004, 8'h01);
    wr(10'h003, 8'hF0);
    rd_chk(10'h002, 8'h3C, "port1 read");
    wr(10'h002, 8'h99);
    rd_chk(10'h1F0, 8'h99, "port1 write");
    rd_chk(10'h0F0, 8'h00, "no bank");
    wr(10'h001, 8'hF0);
    wr(10'h000, 8'h66);
    rd_chk(10'h0F0, 8'h66, "port0 s0");
    rd_chk(10'h1F0, 8'h99, "port0 not s1");
    wr(10'h00E, 8'h01);
    wr(10'h00D, 8'h80);
    wr(10'h00C, 8'h12);
    rd_chk(10'h180, 8'h12, "port2 s1");
    $display("Test indirect done");
    wr(10'h003, 8'hFF);
    op(10'h003, dms_pkg::OP_STEP, 3'd0, 1'b0);
    rd_chk(10'h003, 8'h00, "inc wrap");
    rd_chk(10'h004, 8'h01, "inc no carry");
    op(10'h003, dms_pkg::OP_STEP, 3'd0, 1'b1);
    rd_chk(10'h003, 8'hFF, "dec wrap");
    rd_chk(10'h004, 8'h01, "dec no borrow");
    $display("Test pointer step done");
    wr(10'h001, 8'h00);
    wr(10'h000, 8'h44);
    rd_chk(10'h000, 8'h00, "port as itself");
    rd_chk(10'h001, 8'h00, "port write void");
    wr(10'h03F, 8'h55);
    rd_chk(10'h03F, 8'h00, "unused s0");
    rd_chk(10'h17F, 8'h00, "unused s1");
    wr(10'h004, 8'h02);
    wr(10'h002, 8'h77);
    rd_chk(10'h002, 8'h00, "no sector 2");
    rd_chk(10'h0F0, 8'h66, "sector 2 no alias");
    $display("Test void done");
    wr(10'h007, 8'h77);
    rd_chk(10'h007, 8'h77, "sfr s0");
    wr(10'h140, 8'h21);
    rd_chk(10'h140, 8'h21, "sfr s1");
    wr(10'h005, 8'h11);
    rd_chk(10'h005, 8'h5F, "protected");
    wr(10'h006, 8'h11);
    rd_chk(10'h006, 8'h5C, "reserved");
    wr(10'h004, 8'h00);
    wr(10'h003, 8'h07);
    rd_chk(10'h002, 8'h77, "port1 to sfr");
    $display("Test special area done");
    apb(1'b1, 10'h280, 32'h0000_00EE, junk);
    `CHK("unmapped err", 1'b1, last_err)
    rd_chk(10'h080, 8'hA5, "unmapped no write");
    `CHK("mapped err", 1'b0, last_err)
    $display("Test unmapped done");
    end_of_test();
  end
endmodule : dms_data_memory_sector_addressing_tb
